/* logic/szcb_branch.v */
// branch resolution for greater, less-equal and less-than zero tests
// What this block does
// - greater than zero: pc plus offset operand
// - zero or negative: pc plus offset operand
// - strictly negative: pc plus offset operand
// - immediate form: pc plus extended immediate
// - 16-bit immediate sign-extended to 32 bits
// - after prefix use combined 32-bit immediate
// - not taken: pc advances by four
// - delay flag: slot instruction completes first
// - no delay flag: target follows directly
// - delay variant is same opcode, flag set
// - register form costs 1, 2 or 3
// - immediate form costs 1, 2 or 3
// - hold interrupts until slot completes
`timescale 1ns/1ns
`include "szcb_map.vh"
module szcb_branch #(
	parameter DW = 32,
	parameter AW = 5
) (
	// clock and reset
	input wire clock,
	input wire rst_b,
	// issue
	input wire instr_valid,
	input wire [31:0] instr,
	input wire [DW-1:0] instr_pc,
	input wire prefix_valid,
	input wire [15:0] prefix_hi,
	input wire predict_ok,
	// register file write side
	input wire rf_wr_en,
	input wire [AW-1:0] rf_wr_addr,
	input wire [DW-1:0] rf_wr_data,
	// interrupt requests
	input wire irq_req,
	input wire brk_req,
	// results
	output reg done_r,
	output reg is_branch_r,
	output reg taken_r,
	output reg [DW-1:0] next_pc_r,
	output reg slot_exec_r,
	output reg flush_next_r,
	output reg [1:0] cycles_r,
	output reg irq_hold_r,
	output reg irq_take_r,
	output reg brk_take_r
);
	localparam ST_IDLE = 3'b001;
	localparam ST_READ = 3'b010;
	localparam ST_SLOT = 3'b100;
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [31:0] ins_r;
	reg [DW-1:0] pc_r;
	reg pfx_r;
	reg [15:0] pfx_hi_r;
	reg pok_r;
	wire [DW-1:0] first_source_reg;
	wire [DW-1:0] offset_source_reg;
	wire [5:0] opc;
	wire [3:0] cnd;
	wire is_reg;
	wire is_imm;
	wire dly;
	wire cond_ok;
	wire [DW-1:0] imm_ext;
	wire [DW-1:0] offset;
	wire zero;
	wire neg;
	// register file is read one cycle after issue
	szcb_regfile #(.DW(DW), .AW(AW)) u_rf (
		.clock(clock),
		.wr_en(rf_wr_en),
		.wr_addr(rf_wr_addr),
		.wr_data(rf_wr_data),
		.rd_addr_a(instr[`SZCB_RA_HI:`SZCB_RA_LO]),
		.rd_addr_b(instr[`SZCB_RB_HI:`SZCB_RB_LO]),
		.rd_data_a(first_source_reg),
		.rd_data_b(offset_source_reg)
	);
	assign opc = ins_r[`SZCB_OPC_HI:`SZCB_OPC_LO];
	assign cnd = ins_r[`SZCB_CND_HI:`SZCB_CND_LO];
	assign is_reg = (opc == `SZCB_OPC_REG);
	assign is_imm = (opc == `SZCB_OPC_IMM);
	assign dly = ins_r[`SZCB_DLY_BIT];
	// signed view: sign bit and all-zero test
	assign zero = (first_source_reg == {DW{1'b0}});
	assign neg = first_source_reg[DW-1];
	assign cond_ok = (cnd == `SZCB_CND_GT) ? (!neg && !zero) :
		(cnd == `SZCB_CND_LE) ? (neg || zero) :
		(cnd == `SZCB_CND_LT) ? neg : 1'b0;
	// prefix supplies the upper half instead of sign copies
	assign imm_ext = pfx_r ?
		{pfx_hi_r, ins_r[`SZCB_IMM_HI:`SZCB_IMM_LO]} :
		{{(DW-16){ins_r[`SZCB_IMM_HI]}},
		ins_r[`SZCB_IMM_HI:`SZCB_IMM_LO]};
	assign offset = is_imm ? imm_ext : offset_source_reg;
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (instr_valid) begin
					state_nxt = ST_READ;
				end
			end
			ST_READ: begin
				// slot instruction must retire before hold lifts
				if ((is_reg || is_imm) && cond_ok && dly) begin
					state_nxt = ST_SLOT;
				end else begin
					state_nxt = ST_IDLE;
				end
			end
			ST_SLOT: begin
				if (instr_valid) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= ST_IDLE;
			ins_r <= 32'h00000000;
			pc_r <= `SZCB_PC_RST;
			pfx_r <= 1'b0;
			pfx_hi_r <= 16'h0000;
			pok_r <= 1'b0;
			done_r <= 1'b0;
			is_branch_r <= 1'b0;
			taken_r <= 1'b0;
			next_pc_r <= `SZCB_PC_RST;
			slot_exec_r <= 1'b0;
			flush_next_r <= 1'b0;
			cycles_r <= 2'h0;
			irq_hold_r <= 1'b0;
			irq_take_r <= 1'b0;
			brk_take_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			done_r <= 1'b0;
			irq_take_r <= 1'b0;
			brk_take_r <= 1'b0;
			if (state_r == ST_IDLE && instr_valid) begin
				ins_r <= instr;
				pc_r <= instr_pc;
				pfx_r <= prefix_valid;
				pfx_hi_r <= prefix_hi;
				pok_r <= predict_ok;
			end
			// deferred requests are taken only outside the slot
			if (state_nxt != ST_SLOT) begin
				irq_take_r <= irq_req;
				brk_take_r <= brk_req;
			end
			irq_hold_r <= (state_nxt == ST_SLOT);
			if (state_r == ST_READ) begin
				done_r <= 1'b1;
				is_branch_r <= is_reg || is_imm;
				taken_r <= (is_reg || is_imm) && cond_ok;
				// only the pc is produced; no register write port
				if ((is_reg || is_imm) && cond_ok) begin
					next_pc_r <= pc_r + offset;
				end else begin
					next_pc_r <= pc_r + `SZCB_PC_STEP;
				end
				slot_exec_r <= (is_reg || is_imm) && cond_ok && dly;
				flush_next_r <= (is_reg || is_imm) && cond_ok && !dly;
				// predictor hit makes a taken immediate branch cheap
				if (!(is_reg || is_imm) || !cond_ok) begin
					cycles_r <= `SZCB_CYC_NT;
				end else if (is_imm && pok_r) begin
					cycles_r <= `SZCB_CYC_NT;
				end else if (dly) begin
					cycles_r <= `SZCB_CYC_DLY;
				end else begin
					cycles_r <= `SZCB_CYC_NODLY;
				end
			end
		end
	end
endmodule // szcb_branch

/* logic/szcb_map.vh */
// constants for the signed zero compare branch unit
`ifndef SZCB_MAP_VH
`define SZCB_MAP_VH
`define SZCB_OPC_REG 6'h27
`define SZCB_OPC_IMM 6'h2F
`define SZCB_OPC_HI 31
`define SZCB_OPC_LO 26
`define SZCB_DLY_BIT 25
`define SZCB_CND_HI 24
`define SZCB_CND_LO 21
`define SZCB_RA_HI 20
`define SZCB_RA_LO 16
`define SZCB_RB_HI 15
`define SZCB_RB_LO 11
`define SZCB_IMM_HI 15
`define SZCB_IMM_LO 0
`define SZCB_CND_GT 4'h4
`define SZCB_CND_LE 4'h3
`define SZCB_CND_LT 4'h2
`define SZCB_PC_STEP 32'h00000004
`define SZCB_CYC_NT 2'h1
`define SZCB_CYC_DLY 2'h2
`define SZCB_CYC_NODLY 2'h3
`define SZCB_PC_RST 32'h00000000
`endif

/* logic/szcb_regfile.v */
// two-read-port register file with registered read data
`timescale 1ns/1ns
module szcb_regfile #(
	parameter DW = 32,
	parameter AW = 5
) (
	// clock
	input wire clock,
	// write port
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [DW-1:0] wr_data,
	// read ports
	input wire [AW-1:0] rd_addr_a,
	input wire [AW-1:0] rd_addr_b,
	output reg [DW-1:0] rd_data_a,
	output reg [DW-1:0] rd_data_b
);
	reg [DW-1:0] mem [0:(1<<AW)-1];
	always @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data_a <= mem[rd_addr_a];
		rd_data_b <= mem[rd_addr_b];
	end
endmodule // szcb_regfile

/* testbench/szcb_branch_sva.sv */
// assertions on the zero compare branch unit ports
`timescale 1ns/1ns
module szcb_branch_sva #(
	parameter DW = 32
) (
	// clock, reset and issue
	input wire clock,
	input wire rst_b,
	input wire instr_valid,
	input wire [DW-1:0] instr_pc,
	// results
	input wire done_r,
	input wire taken_r,
	input wire [DW-1:0] next_pc_r,
	input wire slot_exec_r,
	input wire flush_next_r,
	input wire [1:0] cycles_r,
	input wire irq_hold_r,
	input wire irq_take_r,
	input wire brk_take_r
);
default clocking @(posedge clock); endclocking
default disable iff (!rst_b);
// result lands two edges after the taking edge
a_done_lat: assert property (done_r |-> $past(instr_valid, 2))
	else $error("result without request");
a_nt_cost: assert property (done_r && !taken_r |-> cycles_r == 2'h1)
	else $error("bad cost");
a_seq_pc: assert property (done_r && !taken_r
	|-> next_pc_r == $past(instr_pc, 2) + 4) else $error("bad pc");
a_slot_cost: assert property (done_r && slot_exec_r
	|-> taken_r && cycles_r == 2'h2 && irq_hold_r) else $error("bad slot");
a_one_kind: assert property (done_r && taken_r
	|-> slot_exec_r != flush_next_r) else $error("bad kind");
a_flush_cost: assert property (done_r && flush_next_r
	|-> cycles_r[0]) else $error("bad flush cost");
a_irq_held: assert property (irq_hold_r
	|-> !irq_take_r && !brk_take_r) else $error("request leaked");
a_hold_ends: assert property (irq_hold_r && instr_valid
	|=> !irq_hold_r) else $error("hold stuck");
endmodule // szcb_branch_sva
bind szcb_branch szcb_branch_sva #(.DW(DW)) szcb_branch_sva_inst (.clock,
	.rst_b, .instr_valid, .instr_pc, .done_r, .taken_r, .next_pc_r,
	.slot_exec_r, .flush_next_r, .cycles_r, .irq_hold_r, .irq_take_r,
	.brk_take_r);

/* testbench/test_signed_zero_compare_branch.sv */
// self-checking bench for the zero compare branch unit
`timescale 1ns/1ns
`include "szcb_map.vh"
module test_signed_zero_compare_branch;
reg clock = 0, rst_b = 0, instr_valid = 0, prefix_valid = 0, predict_ok = 0;
reg rf_wr_en = 0, irq_req = 0, brk_req = 0, tk, im, dl;
reg [31:0] instr = 0, instr_pc = 0, rf_wr_data = 0, a, b, off;
reg [15:0] prefix_hi = 0;
reg [4:0] rf_wr_addr = 0;
reg [3:0] cnd;
wire done_r, is_branch_r, taken_r, slot_exec_r, flush_next_r;
wire irq_hold_r, irq_take_r, brk_take_r;
wire [31:0] next_pc_r;
wire [1:0] cycles_r;
integer err_total = 0, n_compared = 0, seed = 34299, i, k;
always #20 clock = ~clock;
szcb_branch szcb_branch_inst (.clock, .rst_b, .instr_valid, .instr,
	.instr_pc, .prefix_valid, .prefix_hi, .predict_ok, .rf_wr_en,
	.rf_wr_addr, .rf_wr_data, .irq_req, .brk_req, .done_r, .is_branch_r,
	.taken_r, .next_pc_r, .slot_exec_r, .flush_next_r, .cycles_r,
	.irq_hold_r, .irq_take_r, .brk_take_r);
task check(input [31:0] seen, input [31:0] want);
begin
	n_compared = n_compared + 1;
	if (seen !== want) begin
		err_total = err_total + 1;
		$display("MISMATCH %0t seen %h want %h", $time, seen, want);
	end
end
endtask
task complete_run;
begin
	$display("compared %0d mismatches %0d", n_compared, err_total);
	if (err_total == 0 && n_compared > 0)
		$display("[ PASS ]");
	else
		$display("[ FAIL ]");
	$finish;
end
endtask
task wr(input [4:0] ad, input [31:0] d);
begin
	@(posedge clock);
	rf_wr_en <= 1'b1;
	rf_wr_addr <= ad;
	rf_wr_data <= d;
end
endtask
// bounded wait: a hung unit ends the run
task issue(input [31:0] w);
begin
	@(posedge clock);
	rf_wr_en <= 1'b0;
	instr <= w;
	instr_valid <= 1'b1;
	@(posedge clock);
	instr_valid <= 1'b0;
	k = 0;
	#1;
	while (done_r !== 1'b1 && k < 9) begin
		@(posedge clock);
		#1;
		k = k + 1;
	end
	if (k == 9) begin
		check(0, 1);
		complete_run;
	end
end
endtask
initial begin
	repeat (16) @(posedge clock);
	rst_b <= 1'b1;
	for (i = 0; i < 72; i = i + 1) begin
		cnd = 4'h2 + i % 3;
		im = (i / 3) % 2;
		dl = (i / 6) % 2;
		a = $random(seed);
		b = $random(seed);
		if (i % 4 < 3) a = i % 4 - 1;
		if (i % 8 == 3) a = 32'h80000000;
		wr(5'h1, a);
		prefix_valid <= im & b[16];
		prefix_hi <= b[31:16];
		predict_ok <= b[17];
		instr_pc <= {a[31:2] ^ b[29:0], 2'h0};
		wr(5'h2, b);
		tk = cnd == `SZCB_CND_GT ? $signed(a) > 0 : cnd == `SZCB_CND_LE ?
			$signed(a) <= 0 : $signed(a) < 0;
		off = !im || prefix_valid ? b : {{16{b[15]}}, b[15:0]};
		issue({im ? `SZCB_OPC_IMM : `SZCB_OPC_REG, dl, cnd, 5'h1,
			im ? b[15:0] : 16'h1000});
		check(next_pc_r, tk ? instr_pc + off : instr_pc + 4);
		check(taken_r, tk);
		check(cycles_r, !tk || im && predict_ok ? 1 : dl ? 2 : 3);
		check(slot_exec_r, tk & dl);
		check(flush_next_r, tk & !dl);
		check(is_branch_r, 1);
		if (tk & dl) begin
			@(posedge clock);
			irq_req <= 1'b1;
			brk_req <= 1'b1;
			@(posedge clock);
			// slot word is no prefix, branch or break
			instr <= 32'h0;
			instr_valid <= 1'b1;
			#1;
			check({irq_hold_r, irq_take_r, brk_take_r}, 3'h4);
			@(posedge clock);
			instr_valid <= 1'b0;
			repeat (2) @(posedge clock);
			irq_req <= 1'b0;
			brk_req <= 1'b0;
			#1;
			check({irq_hold_r, irq_take_r, brk_take_r}, 3'h3);
		end
		$display("test %0d done", i);
	end
	issue(32'h0);
	check(is_branch_r, 0);
	check(next_pc_r, instr_pc + 4);
	complete_run;
end
endmodule // test_signed_zero_compare_branch
